// ===== cfg_pkg.sv
package cfg_pkg;

    // logical device numbering inside this block
    localparam int NUM_DEV = 10;
    localparam int DEV_FLOPPY = 0;
    localparam int DEV_PARPORT = 1;
    localparam int DEV_SER1 = 2;
    localparam int DEV_SER2 = 3;
    localparam int DEV_KBC = 4;
    localparam int DEV_MIDI = 5;
    localparam int DEV_GAME = 6;
    localparam int DEV_FAN = 7;
    localparam int DEV_PORTS = 8;
    localparam int DEV_WAKE = 9;

    // devices powered from the standby plane (ports, wake controller)
    localparam logic [9:0] STANDBY_MASK = 10'h300;
    // devices that carry a fast-disable bit
    localparam logic [9:0] FAST_DIS_MASK = 10'h00F;
    // devices whose pins may float when disabled (legacy and fan)
    localparam logic [9:0] FLOAT_MASK = 10'h0FF;
    // devices whose base is confined below 800h
    localparam logic [9:0] LOW_BASE_MASK = 10'h01D;

    // configuration indexes
    localparam logic [7:0] IDX_CHIP_CFG1 = 8'h21;
    localparam logic [7:0] IDX_CHIP_CFG2 = 8'h22;
    localparam logic [7:0] IDX_CHIP_CFG3 = 8'h23;
    localparam logic [7:0] IDX_CHIP_CFG4 = 8'h24;
    localparam logic [7:0] IDX_MOD_DIS = 8'h26;
    localparam logic [7:0] IDX_CLK_CFG = 8'h29;
    localparam logic [7:0] IDX_ACTIVATE = 8'h30;
    localparam logic [7:0] IDX_BASE_HI = 8'h60;
    localparam logic [7:0] IDX_BASE_LO = 8'h61;
    localparam logic [7:0] IDX_VENDOR = 8'hF0;

    // chip_config_one field positions
    localparam int CFG1_PIN_MUX_LOCK = 7;
    localparam int CFG1_PORT_CFG_LOCK = 6;
    localparam int CFG1_WAIT_HI = 3;
    localparam int CFG1_WAIT_LO = 2;
    localparam int CFG1_SW_RESET = 1;
    localparam int CFG1_GLOBAL_EN = 0;
    localparam logic [7:0] CFG1_RESET = 8'h11;
    localparam logic [7:0] CFG1_FIXED = 8'h10;

    // module_disable_config field positions
    localparam int MDIS_LOCK = 7;
    localparam logic [7:0] MDIS_SCRATCH = 8'h60;
    localparam logic [7:0] MDIS_FAST = 8'h0F;
    localparam logic [7:0] MDIS_RESET = 8'h00;

    // clock generator: bit 0 is the enable that locks the whole register
    localparam int CLK_GEN_EN = 0;
    localparam logic [7:0] CLK_RESET = 8'h00;

    // vendor register float-control bit
    localparam int VENDOR_FLOAT = 0;

    // register bit kinds
    typedef enum logic [1:0] {
        BIT_RW = 2'h0,
        BIT_W1C = 2'h1,
        BIT_W1S = 2'h2,
        BIT_WO = 2'h3
    } bit_kind_type;

    // one configuration access from the host decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] dev;
        logic [7:0] index;
        logic [7:0] data;
    } cfg_access_type;

    // one runtime io cycle seen on the lpc side
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
    } io_cycle_type;

    // per-device resources released while disabled
    typedef struct packed {
        logic irq_assigned;
        logic dma_assigned;
        logic range_assigned;
        logic clock_run;
        logic pins_float;
    } dev_status_type;

endpackage : cfg_pkg

// ===== base_decode.sv
`timescale 1ns/1ps
`default_nettype none
// decodes one device's runtime range from its programmed base
module base_decode #(
    parameter int RANGE_BITS = 3
) (
    input wire logic [15:0] base,
    input wire logic [15:0] addr,
    input wire logic enabled,
    output logic hit,
    output logic [4:0] offset
);
    import cfg_pkg::*;

    // upper bits compared in full, low bits form the offset
    wire logic [15:0] upper_mask = 16'hFFFF << RANGE_BITS;
    wire logic match = ((addr & upper_mask) == (base & upper_mask));

    // a disabled device answers no runtime cycle
    assign hit = match && enabled;
    assign offset = 5'(addr & ~upper_mask);
endmodule : base_decode
`default_nettype wire

// ===== lock_bit_cell.sv
`timescale 1ns/1ps
`default_nettype none
// one 8-bit register with per-bit kind and a lock mask
module lock_bit_cell #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] W1S_BITS = 8'h00,
    parameter logic [7:0] W1C_BITS = 8'h00,
    parameter logic [7:0] WO_BITS = 8'h00,
    parameter logic [7:0] FIXED_BITS = 8'h00,
    parameter logic [7:0] FIXED_VAL = 8'h00
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic soft_reset,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] locked,
    input wire logic [7:0] hw_set,
    output logic [7:0] value,
    output logic [7:0] rdata
);
    import cfg_pkg::*;

    logic [7:0] val_r; // stored bits
    logic [7:0] val_nxt; // next stored bits

    // writable bits are those not locked and not fixed
    wire logic [7:0] open_bits = ~locked & ~FIXED_BITS;
    wire logic [7:0] rw_bits = open_bits & ~W1S_BITS & ~W1C_BITS;
    // write-one bit types, zero writes leave them alone
    wire logic [7:0] set_bits = wr ? (wdata & W1S_BITS & open_bits) : 8'h00;
    wire logic [7:0] clr_bits = wr ? (wdata & W1C_BITS & open_bits) : 8'h00;
    wire logic [7:0] wr_val = wr ? ((val_r & ~rw_bits) | (wdata & rw_bits)) : val_r;

    // hardware sets beat a same-cycle clear
    assign val_nxt = (((wr_val | set_bits) & ~clr_bits) | hw_set) & ~FIXED_BITS
                     | FIXED_VAL;

    // lock bits survive soft reset; soft reset reloads unlocked bits only
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            val_r <= RESET_VAL;
        end else if (soft_reset) begin
            val_r <= (val_r & locked) | (RESET_VAL & ~locked);
        end else begin
            val_r <= val_nxt;
        end
    end

    assign value = val_r;
    // write-only bits read as zero
    assign rdata = val_r & ~WO_BITS;
endmodule : lock_bit_cell
`default_nettype wire

// ===== module_enable_lock_decode.sv
`timescale 1ns/1ps
`default_nettype none
module module_enable_lock_decode #(
    parameter int NUM_PORTS = 13
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hw_reset_n,
    input wire cfg_pkg::cfg_access_type cfg_acc,
    output logic [7:0] cfg_rdata,
    input wire cfg_pkg::io_cycle_type io_cyc,
    output logic [cfg_pkg::NUM_DEV-1:0] io_hit,
    output logic [4:0] io_offset,
    output logic io_sync_en,
    output cfg_pkg::dev_status_type [cfg_pkg::NUM_DEV-1:0] dev_status,
    output logic [1:0] lpc_wait_states,
    output logic soft_reset_pulse,
    output logic [23:0] pin_mux_config,
    output logic [7:0] clock_gen_config,
    input wire logic port_config_lock,
    input wire logic [NUM_PORTS-1:0] per_port_lock,
    input wire logic fan_config_lock,
    input wire logic wake_config_lock,
    output logic [NUM_PORTS-1:0] port_cfg_write_allow,
    output logic [NUM_PORTS-1:0] port_data_write_allow,
    output logic fan_cfg_write_allow,
    output logic wake_cfg_write_allow,
    output logic led_style_write_allow
);
    import cfg_pkg::*;

    // offset bits per device, range of 2 to 32 bytes
    localparam int RANGE_BITS [NUM_DEV] = '{3, 3, 3, 3, 1, 1, 3, 4, 5, 5};

    // host-visible strobes for the chip-level registers
    wire logic wr_cfg1 = cfg_acc.wr && (cfg_acc.index == IDX_CHIP_CFG1);
    wire logic wr_cfg2 = cfg_acc.wr && (cfg_acc.index == IDX_CHIP_CFG2);
    wire logic wr_cfg3 = cfg_acc.wr && (cfg_acc.index == IDX_CHIP_CFG3);
    wire logic wr_cfg4 = cfg_acc.wr && (cfg_acc.index == IDX_CHIP_CFG4);
    wire logic wr_mdis = cfg_acc.wr && (cfg_acc.index == IDX_MOD_DIS);
    wire logic wr_clk = cfg_acc.wr && (cfg_acc.index == IDX_CLK_CFG);

    logic [7:0] cfg1_val; // chip_config_one
    logic [7:0] cfg1_rd;
    logic [7:0] cfg2_val; // chip_config_two
    logic [7:0] cfg3_val; // chip_config_three
    logic [7:0] cfg4_val; // chip_config_four
    logic [7:0] mdis_val; // module_disable_config
    logic [7:0] clk_val; // clock_gen_config
    logic soft_reset_r; // one-cycle soft reset request

    // reset lines: power-up (reset_n) also via hardware reset
    wire logic any_reset_n = reset_n & hw_reset_n;
    wire logic pin_mux_lock = cfg1_val[CFG1_PIN_MUX_LOCK];
    wire logic fast_disable_lock = mdis_val[MDIS_LOCK];
    wire logic clock_gen_enable_lock = clk_val[CLK_GEN_EN];
    wire logic global_device_enable = cfg1_val[CFG1_GLOBAL_EN];

    // lock masks for chip_config_one: wait field by pin-mux lock
    // global enable by fast-disable lock lock bits lock themselves
    wire logic [7:0] cfg1_lock = {pin_mux_lock, cfg1_val[CFG1_PORT_CFG_LOCK], 2'b00,
                                  {2{pin_mux_lock}}, 1'b0, fast_disable_lock};
    wire logic [7:0] mux_lock = {8{pin_mux_lock}};
    // fast disable bits and its own lock, not scratch
    wire logic [7:0] mdis_lock = {8{fast_disable_lock}} & ~MDIS_SCRATCH;
    wire logic [7:0] clk_lock = {8{clock_gen_enable_lock}};

    // chip_config_one: locks are w1s, soft reset bit is write-only
    lock_bit_cell #(
        .RESET_VAL(CFG1_RESET),
        .W1S_BITS(8'hC0),
        .WO_BITS(8'h02),
        .FIXED_BITS(8'h30),
        .FIXED_VAL(CFG1_FIXED)
    ) u_cfg1 (
        .ref_clk(ref_clk),
        .reset_n(any_reset_n),
        .soft_reset(soft_reset_r),
        .wr(wr_cfg1),
        .wdata(cfg_acc.data),
        .locked(cfg1_lock),
        .hw_set(8'h00),
        .value(cfg1_val),
        .rdata(cfg1_rd)
    );

    // soft reset request self-clears the cycle after it is written
    always_ff @(posedge ref_clk or negedge any_reset_n) begin
        if (!any_reset_n) begin
            soft_reset_r <= 1'b0;
        end else begin
            soft_reset_r <= wr_cfg1 && cfg_acc.data[CFG1_SW_RESET];
        end
    end

    // pin-mux registers two to four share one lock
    lock_bit_cell u_cfg2 (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .soft_reset(1'b0),
        .wr(wr_cfg2),
        .wdata(cfg_acc.data),
        .locked(mux_lock),
        .hw_set(8'h00),
        .value(cfg2_val),
        .rdata()
    );
    lock_bit_cell u_cfg3 (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .soft_reset(1'b0),
        .wr(wr_cfg3),
        .wdata(cfg_acc.data),
        .locked(mux_lock),
        .hw_set(8'h00),
        .value(cfg3_val),
        .rdata()
    );
    lock_bit_cell u_cfg4 (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .soft_reset(1'b0),
        .wr(wr_cfg4),
        .wdata(cfg_acc.data),
        .locked(mux_lock),
        .hw_set(8'h00),
        .value(cfg4_val),
        .rdata()
    );

    // module disable register, lock is w1s, reserved bit 4 fixed
    lock_bit_cell #(
        .RESET_VAL(MDIS_RESET),
        .W1S_BITS(8'h80),
        .FIXED_BITS(8'h10)
    ) u_mdis (
        .ref_clk(ref_clk),
        .reset_n(any_reset_n),
        .soft_reset(soft_reset_r),
        .wr(wr_mdis),
        .wdata(cfg_acc.data),
        .locked(mdis_lock),
        .hw_set(8'h00),
        .value(mdis_val),
        .rdata()
    );

    // clock generator register, enable bit is w1s lock
    lock_bit_cell #(
        .RESET_VAL(CLK_RESET),
        .W1S_BITS(8'h01)
    ) u_clk (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .soft_reset(1'b0),
        .wr(wr_clk),
        .wdata(cfg_acc.data),
        .locked(clk_lock),
        .hw_set(8'h00),
        .value(clk_val),
        .rdata()
    );

    // per-device activation, base and vendor registers
    logic [NUM_DEV-1:0] activate_r; // activation bits
    logic [15:0] base_r [NUM_DEV]; // programmed bases
    logic [NUM_DEV-1:0] float_r; // vendor float-control bits

    // forces alignment and range limits onto a written base
    function automatic logic [15:0] shape_base(input int dev, input logic [15:0] raw);
        logic [15:0] b;
        b = raw & (16'hFFFF << RANGE_BITS[dev]);
        if (LOW_BASE_MASK[dev]) begin
            b = b & 16'h07FF;
        end
        if (dev == DEV_PARPORT) begin
            b = b & 16'h03F8;
        end
        // other devices keep the full sixteen bits
        return b;
    endfunction : shape_base

    wire logic dev_sel_ok = (32'(cfg_acc.dev) < NUM_DEV);

    // device configuration writes stay open whatever the enable state
    always_ff @(posedge ref_clk or negedge any_reset_n) begin
        if (!any_reset_n) begin
            activate_r <= '0;
            float_r <= '0;
            for (int i = 0; i < NUM_DEV; i++) begin
                base_r[i] <= 16'h0000;
            end
        end else if (soft_reset_r) begin
            activate_r <= '0;
            float_r <= '0;
            for (int i = 0; i < NUM_DEV; i++) begin
                base_r[i] <= 16'h0000;
            end
        end else if (cfg_acc.wr && dev_sel_ok) begin
            for (int i = 0; i < NUM_DEV; i++) begin
                if (cfg_acc.dev == 4'(i)) begin
                    if (cfg_acc.index == IDX_ACTIVATE) begin
                        activate_r[i] <= cfg_acc.data[0];
                    end
                    if (cfg_acc.index == IDX_VENDOR) begin
                        float_r[i] <= cfg_acc.data[VENDOR_FLOAT];
                    end
                    if (cfg_acc.index == IDX_BASE_HI) begin
                        base_r[i] <= shape_base(i, {cfg_acc.data, base_r[i][7:0]});
                    end
                    if (cfg_acc.index == IDX_BASE_LO) begin
                        base_r[i] <= shape_base(i, {base_r[i][15:8], cfg_acc.data});
                    end
                end
            end
        end
    end

    // fast-disable bits widened to the device vector, only four devices carry one
    wire logic [NUM_DEV-1:0] fast_off = FAST_DIS_MASK & NUM_DEV'(mdis_val[3:0]);
    // enable combines the three controls
    logic [NUM_DEV-1:0] dev_enabled;
    always_comb begin
        for (int i = 0; i < NUM_DEV; i++) begin
            dev_enabled[i] = activate_r[i] && global_device_enable && !fast_off[i];
        end
    end

    // runtime range decoders, one per device
    logic [4:0] dev_off [NUM_DEV];
    for (genvar g = 0; g < NUM_DEV; g++) begin : g_dec
        base_decode #(
            .RANGE_BITS(RANGE_BITS[g])
        ) u_dec (
            .base(base_r[g]),
            .addr(io_cyc.addr),
            .enabled(dev_enabled[g] && io_cyc.valid),
            .hit(io_hit[g]),
            .offset(dev_off[g])
        );
    end

    // offset of the lowest hitting device; no hit means no sync
    always_comb begin
        io_offset = 5'h00;
        for (int i = NUM_DEV - 1; i >= 0; i--) begin
            if (io_hit[i]) begin
                io_offset = dev_off[i];
            end
        end
    end
    assign io_sync_en = |io_hit;

    // resource and clock status per device
    always_comb begin
        for (int i = 0; i < NUM_DEV; i++) begin
            dev_status[i].irq_assigned = dev_enabled[i];
            dev_status[i].range_assigned = dev_enabled[i];
            dev_status[i].dma_assigned = dev_enabled[i] && !STANDBY_MASK[i];
            // standby devices keep running others gate
            dev_status[i].clock_run = dev_enabled[i] || STANDBY_MASK[i];
            // float only when disabled and float bit set
            dev_status[i].pins_float = FLOAT_MASK[i] && !dev_enabled[i] && float_r[i];
        end
    end

    // configuration read mux; reads always allowed
    logic [7:0] dev_rd;
    always_comb begin
        dev_rd = 8'h00;
        for (int i = 0; i < NUM_DEV; i++) begin
            if (cfg_acc.dev == 4'(i)) begin
                case (cfg_acc.index)
                    IDX_ACTIVATE: dev_rd = {7'h00, activate_r[i]};
                    IDX_BASE_HI: dev_rd = base_r[i][15:8];
                    IDX_BASE_LO: dev_rd = base_r[i][7:0];
                    IDX_VENDOR: dev_rd = {7'h00, float_r[i]};
                    default: dev_rd = 8'h00;
                endcase
            end
        end
    end

    always_comb begin
        case (cfg_acc.index)
            IDX_CHIP_CFG1: cfg_rdata = cfg1_rd;
            IDX_CHIP_CFG2: cfg_rdata = cfg2_val;
            IDX_CHIP_CFG3: cfg_rdata = cfg3_val;
            IDX_CHIP_CFG4: cfg_rdata = cfg4_val;
            IDX_MOD_DIS: cfg_rdata = mdis_val;
            IDX_CLK_CFG: cfg_rdata = clk_val;
            default: cfg_rdata = dev_rd;
        endcase
    end

    // chip-level outputs
    assign lpc_wait_states = cfg1_val[CFG1_WAIT_HI:CFG1_WAIT_LO];
    assign soft_reset_pulse = soft_reset_r;
    assign pin_mux_config = {cfg4_val, cfg3_val, cfg2_val};
    assign clock_gen_config = clk_val;

    // write permissions handed to the port, fan and wake register files
    assign port_cfg_write_allow = {NUM_PORTS{!port_config_lock}};
    assign port_data_write_allow = ~per_port_lock;
    assign fan_cfg_write_allow = !fan_config_lock;
    assign wake_cfg_write_allow = !wake_config_lock;
    assign led_style_write_allow = !wake_config_lock;
endmodule : module_enable_lock_decode
`default_nettype wire

// ===== module_enable_lock_decode_chk.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks on enable, release, soft reset and lock-allow outputs
module module_enable_lock_decode_chk
    import cfg_pkg::*;
#(
    parameter int NUM_PORTS = 13
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire cfg_access_type cfg_acc,
    input wire logic [7:0] cfg_rdata,
    input wire logic [NUM_DEV-1:0] io_hit,
    input wire logic io_sync_en,
    input wire dev_status_type [NUM_DEV-1:0] dev_status,
    input wire logic soft_reset_pulse,
    input wire logic port_config_lock,
    input wire logic [NUM_PORTS-1:0] per_port_lock,
    input wire logic fan_config_lock,
    input wire logic wake_config_lock,
    input wire logic [NUM_PORTS-1:0] port_cfg_write_allow,
    input wire logic [NUM_PORTS-1:0] port_data_write_allow,
    input wire logic fan_cfg_write_allow,
    input wire logic wake_cfg_write_allow,
    input wire logic led_style_write_allow
);
    logic [NUM_DEV-1:0] rng_v; // range assigned per device
    logic [NUM_DEV-1:0] irq_v; // irq assigned per device
    logic [NUM_DEV-1:0] clk_v; // clock running per device
    logic [NUM_DEV-1:0] flt_v; // pins floated per device
    // flatten the status array into vectors
    always_comb begin
        for (int i = 0; i < NUM_DEV; i++) begin
            rng_v[i] = dev_status[i].range_assigned;
            irq_v[i] = dev_status[i].irq_assigned;
            clk_v[i] = dev_status[i].clock_run;
            flt_v[i] = dev_status[i].pins_float;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_hit_needs_range; (io_hit & ~rng_v) == 10'h000; endproperty
    property p_sync_any; io_sync_en == (|io_hit); endproperty
    property p_irq_follows; irq_v == rng_v; endproperty
    property p_main_clock; (clk_v & ~STANDBY_MASK) == (rng_v & ~STANDBY_MASK); endproperty
    property p_standby_runs; (clk_v & STANDBY_MASK) == STANDBY_MASK; endproperty
    property p_float_off; (flt_v & (rng_v | ~FLOAT_MASK)) == 10'h000; endproperty
    property p_swrst;
        cfg_acc.wr && cfg_acc.index == IDX_CHIP_CFG1 && cfg_acc.data[CFG1_SW_RESET]
            |=> soft_reset_pulse ##1 !soft_reset_pulse;
    endproperty
    property p_wo_zero;
        cfg_acc.rd && cfg_acc.index == IDX_CHIP_CFG1
            |-> !cfg_rdata[CFG1_SW_RESET] && cfg_rdata[5:4] == 2'h1;
    endproperty
    property p_port_allow; port_cfg_write_allow == {NUM_PORTS{!port_config_lock}}; endproperty
    property p_data_allow; port_data_write_allow == ~per_port_lock; endproperty
    property p_fan_allow; fan_cfg_write_allow == !fan_config_lock; endproperty
    property p_wake_allow;
        wake_cfg_write_allow == !wake_config_lock && led_style_write_allow == !wake_config_lock;
    endproperty
    a_hit_needs_range: assert property (p_hit_needs_range) else $error("idle hit");
    a_sync_any: assert property (p_sync_any) else $error("sync wrong");
    a_irq_follows: assert property (p_irq_follows) else $error("irq kept");
    a_main_clock: assert property (p_main_clock) else $error("main clock");
    a_standby_runs: assert property (p_standby_runs) else $error("standby stop");
    a_float_off: assert property (p_float_off) else $error("float on");
    a_swrst: assert property (p_swrst) else $error("soft reset");
    a_wo_zero: assert property (p_wo_zero) else $error("wo read");
    a_port_allow: assert property (p_port_allow) else $error("port allow");
    a_data_allow: assert property (p_data_allow) else $error("data allow");
    a_fan_allow: assert property (p_fan_allow) else $error("fan allow");
    a_wake_allow: assert property (p_wake_allow) else $error("wake allow");
    c_swrst: cover property (soft_reset_pulse);
    c_sync: cover property (io_sync_en);
    c_float: cover property (|flt_v);
endmodule : module_enable_lock_decode_chk
bind module_enable_lock_decode module_enable_lock_decode_chk #(.NUM_PORTS(NUM_PORTS)) chk_i (.*);
`default_nettype wire

// ===== lpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side: one-cycle config strobes and io probes, payload scrambled when idle
module lpc_host_model
    import cfg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [7:0] cfg_rdata,
    input wire logic [NUM_DEV-1:0] io_hit,
    input wire logic [4:0] io_offset,
    output var cfg_access_type cfg_acc,
    output var io_cycle_type io_cyc
);
    initial begin
        cfg_acc = '0;
        io_cyc = '0;
    end
    // callers pass reserved bits at zero or their fixed value
    task cfg_write(input logic [3:0] dev, input logic [7:0] idx, input logic [7:0] data);
        @(negedge ref_clk);
        cfg_acc = '{wr: 1'b1, rd: 1'b0, dev: dev, index: idx, data: data};
        @(posedge ref_clk);
        @(negedge ref_clk);
        cfg_acc = {2'h0, ~cfg_acc[19:0]};
    endtask : cfg_write
    // read data sampled at the edge that sees the strobe
    task cfg_read(input logic [3:0] dev, input logic [7:0] idx, output logic [7:0] data);
        @(negedge ref_clk);
        cfg_acc = '{wr: 1'b0, rd: 1'b1, dev: dev, index: idx, data: 8'h00};
        @(posedge ref_clk);
        data = cfg_rdata;
        @(negedge ref_clk);
        cfg_acc = {2'h0, ~cfg_acc[19:0]};
    endtask : cfg_read
    // runtime cycle; hit and offset taken at the sampling edge
    task io_probe(input logic [15:0] addr, output logic [9:0] hit, output logic [4:0] off);
        @(negedge ref_clk);
        io_cyc = '{valid: 1'b1, addr: addr};
        @(posedge ref_clk);
        hit = io_hit;
        off = io_offset;
        @(negedge ref_clk);
        io_cyc = {1'b0, ~io_cyc.addr};
    endtask : io_probe
endmodule : lpc_host_model
`default_nettype wire

// ===== module_enable_lock_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench: decode, enables, locks and resets
module module_enable_lock_decode_tb;
    import cfg_pkg::*;
    localparam int RB [NUM_DEV] = '{3, 3, 3, 3, 1, 1, 3, 4, 5, 5}; // offset bits per device
    logic ref_clk = 1'b0, reset_n = 1'b0, hw_reset_n = 1'b1;
    cfg_access_type cfg_acc;
    io_cycle_type io_cyc;
    logic [7:0] cfg_rdata, clock_gen_config;
    logic [NUM_DEV-1:0] io_hit;
    logic [4:0] io_offset;
    logic io_sync_en, soft_reset_pulse, fan_cfg_write_allow, wake_cfg_write_allow;
    logic led_style_write_allow;
    dev_status_type [NUM_DEV-1:0] dev_status;
    logic [1:0] lpc_wait_states;
    logic [23:0] pin_mux_config;
    logic port_config_lock = 1'b0, fan_config_lock = 1'b0, wake_config_lock = 1'b0;
    logic [12:0] per_port_lock = 13'h0, port_cfg_write_allow, port_data_write_allow;
    int num_errors = 0, compares = 0;
    integer seed = 32'h5817;
    always #2.5 ref_clk = ~ref_clk;
    // lock inputs wander at random, away from the sampling edge
    always @(negedge ref_clk) begin
        {port_config_lock, fan_config_lock, wake_config_lock, per_port_lock} = 16'($random(seed));
    end
    module_enable_lock_decode #(.NUM_PORTS(13)) dut (.*);
    lpc_host_model host (.*);
    // one comparison, counted
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    task wr(input int d, input logic [7:0] idx, input logic [7:0] v);
        host.cfg_write(4'(d), idx, v);
    endtask : wr
    task rd_chk(input int d, input logic [7:0] idx, input logic [7:0] exp, input string what);
        logic [7:0] v;
        host.cfg_read(4'(d), idx, v);
        chk(v, exp, what);
    endtask : rd_chk
    // aligned and range-limited base expected for a device
    function automatic logic [15:0] exp_base(input int d, input logic [15:0] raw);
        logic [15:0] m;
        m = (d == DEV_PARPORT) ? 16'h03F8 : (LOW_BASE_MASK[d] ? 16'h07FF : 16'hFFFF);
        return raw & m & ~((16'h1 << RB[d]) - 16'h1);
    endfunction : exp_base
    task end_sim;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    // watchdog well beyond the few hundred cycles needed
    initial begin
        #100000;
        num_errors++;
        end_sim();
    end
    // main sequence
    initial begin
        logic [15:0] raw, eb, a;
        logic [9:0] hit;
        logic [4:0] off, go;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk) reset_n = 1'b1;
        rd_chk(0, IDX_CHIP_CFG1, CFG1_RESET, "cfg1 reset");
        rd_chk(0, IDX_MOD_DIS, MDIS_RESET, "disable reset");
        rd_chk(0, IDX_CLK_CFG, CLK_RESET, "clock reset");
        // every device: all-ones base first, then random bases
        for (int p = 0; p < 2; p++) begin
            for (int d = 0; d < NUM_DEV; d++) begin
                raw = (p == 0) ? 16'hFFFF : 16'($random(seed));
                eb = exp_base(d, raw);
                wr(d, IDX_BASE_HI, raw[15:8]);
                wr(d, IDX_BASE_LO, raw[7:0]);
                wr(d, IDX_ACTIVATE, 8'h01);
                off = 5'($random(seed)) & 5'((1 << RB[d]) - 1);
                a = eb | 16'(off);
                host.io_probe(a, hit, go);
                chk(hit, 32'h1 << d, "hit");
                chk(go, off, "offset");
                host.io_probe(a ^ 16'h8000, hit, go);
                chk(hit, 32'h0, "upper bit miss");
                wr(0, IDX_CHIP_CFG1, 8'h10);
                host.io_probe(a, hit, go);
                chk(hit, 32'h0, "global off miss");
                wr(0, IDX_CHIP_CFG1, 8'h11);
                wr(d, IDX_ACTIVATE, 8'h00);
                host.io_probe(a, hit, go);
                chk(hit, 32'h0, "inactive miss");
                rd_chk(d, IDX_BASE_HI, eb[15:8], "base hi");
                rd_chk(d, IDX_BASE_LO, eb[7:0], "base lo");
            end
        end
        // pin-mux lock freezes wait states and config two to four
        wr(0, IDX_CHIP_CFG1, 8'h1D);
        wr(0, IDX_CHIP_CFG2, 8'hF3);
        wr(0, IDX_CHIP_CFG3, 8'hF0);
        wr(0, IDX_CHIP_CFG4, 8'h40);
        chk(lpc_wait_states, 32'h3, "wait states");
        wr(0, IDX_CHIP_CFG1, 8'h9D);
        wr(0, IDX_CHIP_CFG1, 8'h11);
        wr(0, IDX_CHIP_CFG2, 8'h00);
        rd_chk(0, IDX_CHIP_CFG1, 8'h9D, "mux lock sticky");
        chk(pin_mux_config, 32'h40F0F3, "mux locked");
        wr(0, IDX_CHIP_CFG1, 8'h10);
        rd_chk(0, IDX_CHIP_CFG1, 8'h9C, "enable outside mux lock");
        wr(0, IDX_CHIP_CFG1, 8'h11);
        // fast disable, float control, fast lock, soft reset
        wr(DEV_FLOPPY, IDX_VENDOR, 8'h01);
        wr(DEV_FLOPPY, IDX_ACTIVATE, 8'h01);
        chk(dev_status[DEV_FLOPPY], 32'h1E, "floppy on");
        wr(0, IDX_MOD_DIS, 8'h01);
        chk(dev_status[DEV_FLOPPY], 32'h01, "floppy fast off");
        wr(0, IDX_MOD_DIS, 8'h81);
        wr(0, IDX_MOD_DIS, 8'h60);
        rd_chk(0, IDX_MOD_DIS, 8'hE1, "fast lock");
        wr(0, IDX_CHIP_CFG1, 8'h10);
        rd_chk(0, IDX_CHIP_CFG1, 8'h9D, "enable locked");
        wr(0, IDX_CHIP_CFG1, 8'h13);
        // let the soft reset pulse land before reading back
        @(negedge ref_clk);
        rd_chk(0, IDX_MOD_DIS, 8'h81, "soft keeps lock");
        chk(dev_status[DEV_FLOPPY], 32'h00, "soft clears float");
        // clock enable locks its own register
        wr(0, IDX_CLK_CFG, 8'h01);
        wr(0, IDX_CLK_CFG, 8'hFE);
        chk(clock_gen_config, 32'h01, "clock locked");
        // hardware reset, then power-up reset
        @(negedge ref_clk) hw_reset_n = 1'b0;
        @(negedge ref_clk) hw_reset_n = 1'b1;
        rd_chk(0, IDX_MOD_DIS, 8'h00, "hw clears lock");
        rd_chk(0, IDX_CHIP_CFG1, CFG1_RESET, "hw cfg1");
        chk(pin_mux_config, 32'h40F0F3, "mux kept");
        @(negedge ref_clk) reset_n = 1'b0;
        @(negedge ref_clk) reset_n = 1'b1;
        chk(pin_mux_config, 32'h0, "power clears mux");
        chk(clock_gen_config, 32'h0, "power clears clock");
        end_sim();
    end
endmodule : module_enable_lock_decode_tb
`default_nettype wire
